// ===== rtl/tmz_pkg.sv
package tmz_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_COUNT = 8'h01;
    localparam logic [7:0] IDX_INTCTL = 8'h0B;
    localparam logic [7:0] IDX_CONFIG = 8'h81;
    localparam logic [7:0] IDX_PORTA_DIR = 8'h85;
    localparam logic [7:0] IDX_CTRL = 8'hC0;
    localparam int ADDR_LSB = 2;
    localparam logic [11:0] ADDR_COUNT = {2'h0, IDX_COUNT, 2'h0};
    localparam logic [11:0] ADDR_INTCTL = {2'h0, IDX_INTCTL, 2'h0};
    localparam logic [11:0] ADDR_CONFIG = {2'h0, IDX_CONFIG, 2'h0};
    localparam logic [11:0] ADDR_PORTA_DIR = {2'h0, IDX_PORTA_DIR, 2'h0};
    localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    // Configuration fields
    localparam int CFG_SRC_BIT = 5;
    localparam int CFG_EDGE_BIT = 4;
    localparam int CFG_ASSIGN_BIT = 3;
    localparam int CFG_RATIO_LSB = 0;
    localparam int CFG_RATIO_W = 3;
    localparam logic [7:0] CONFIG_RST = 8'hFF;
    localparam logic [7:0] PORTA_DIR_RST = 8'hFF;
    // Interrupt control fields
    localparam int IC_GIE_BIT = 7;
    localparam int IC_OVIE_BIT = 5;
    localparam int IC_OVF_BIT = 2;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [7:0] INTCTL_MASK = 8'hA4;
    // Control register fields
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_WDCLR_BIT = 1;
    // Write holdoff, in instruction cycles
    localparam logic [1:0] HOLDOFF_CYC = 2'h2;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
endpackage : tmz_pkg

// ===== rtl/tmz_timer0.sv
// Function
// - Source clear: count every instruction cycle
// - Count write stalls increments two cycles
// - Source set: count external pin edges
// - Edge bit: clear rising, set falling
// - Assign bit routes divider timer or watchdog
// - Divider count has no register address
// - Ratio bits pick 1:2 to 1:256
// - Wrap from max sets overflow flag
// - Enable bit masks request, not flag
// - Flag stays until software clears it
// - Sleep halts the timer completely
// - Divider output sampled on two phases; here sampled at phase four only, phase two holds a copy
// - Divider symmetric; source period limit applies
// - One shared divider, never both users
// - Count writes clear timer-assigned divider
// - Watchdog clear resets watchdog-assigned divider and watchdog
// - Divider reassignment allowed any time
`timescale 1ns/100ps
module tmz_timer0 #(
    parameter int WIDTH = 8,
    parameter int DIV_W = 8
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External count pin
    input wire logic timer_ext_clock_pin,
    // Watchdog side
    output logic wdt_tick,
    output logic wdt_clear,
    // Processor side
    output logic timer_irq,
    output logic port_a_dir_0
);
    initial begin
        if (WIDTH != 8 || DIV_W != 8) begin
            $error("tmz_timer0 supports only 8-bit count and divider");
        end
    end

    // Phase sequencer: four phases per instruction cycle
    typedef enum logic [3:0] {
        PH1 = 4'h1,
        PH2 = 4'h2,
        PH3 = 4'h4,
        PH4 = 4'h8
    } tmz_phase_e;
    tmz_phase_e phase_ff;
    tmz_phase_e nxt_phase;

    logic [7:0] count_ff;
    logic [7:0] intctl_ff;
    logic [7:0] config_ff;
    logic [7:0] porta_dir_ff;
    logic sleep_ff;
    logic [7:0] div_ff;
    logic [1:0] hold_ff;
    logic pin_q_ff;
    logic src_prev_ff;
    logic samp2_ff;
    logic samp4_ff;
    logic wd_prev_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic wdt_tick_ff;
    logic wdt_clear_ff;
    logic irq_ff;
    logic porta_ff;

    // Bus decode
    wire access = psel && penable && !pready_ff;
    // Writes land at the edge where the master sees ready
    wire wr = psel && penable && pready_ff && pwrite;
    wire hit_count = paddr == tmz_pkg::ADDR_COUNT;
    wire hit_intctl = paddr == tmz_pkg::ADDR_INTCTL;
    wire hit_config = paddr == tmz_pkg::ADDR_CONFIG;
    wire hit_porta = paddr == tmz_pkg::ADDR_PORTA_DIR;
    wire hit_ctrl = paddr == tmz_pkg::ADDR_CTRL;
    wire hit_any = hit_count | hit_intctl | hit_config | hit_porta | hit_ctrl;
    wire wr_count = wr && hit_count;
    wire wr_intctl = wr && hit_intctl;
    wire wr_config = wr && hit_config;
    wire wr_porta = wr && hit_porta;
    wire wr_ctrl = wr && hit_ctrl;
    wire wd_clear_cmd = wr_ctrl && pwdata[tmz_pkg::CTRL_WDCLR_BIT];

    // Configuration fields
    wire src_ext = config_ff[tmz_pkg::CFG_SRC_BIT];
    wire edge_fall = config_ff[tmz_pkg::CFG_EDGE_BIT];
    wire to_wdt = config_ff[tmz_pkg::CFG_ASSIGN_BIT];
    wire [2:0] ratio = config_ff[tmz_pkg::CFG_RATIO_LSB +: tmz_pkg::CFG_RATIO_W];
    wire inst_cycle = phase_ff == PH4;

    // Divider input: pin (edge adjusted) or instruction cycle tick
    wire pin_edge = src_ext ? (pin_q_ff ^ edge_fall) : 1'b0;
    wire src_level = src_ext ? pin_edge : inst_cycle;
    wire src_rise = src_level && !src_prev_ff;
    // Ratio code n taps divider bit n, giving 1:2 up to 1:256
    wire div_out = div_ff[ratio];
    // No divider: the raw edge-adjusted input feeds the sampler
    wire pre_out = to_wdt ? pin_edge : div_out;
    wire div_clear = (wr_count && !to_wdt) || (wd_clear_cmd && to_wdt);
    wire div_step = src_rise && !sleep_ff;
    // Timer increment condition
    // Phase-two copy lags phase-four sample; look once, at phase two
    wire ext_inc = phase_ff == PH2 && samp4_ff && !samp2_ff;
    wire tick = (!src_ext && to_wdt) ? inst_cycle : ext_inc;
    wire inc = tick && !sleep_ff && hold_ff == 2'h0 && !wr_count;
    wire wrap = inc && count_ff == tmz_pkg::COUNT_MAX;

    assign nxt_phase = phase_ff == PH1 ? PH2 :
                       phase_ff == PH2 ? PH3 :
                       phase_ff == PH3 ? PH4 : PH1;

    // Interrupt control next value: hardware set wins over software clear
    logic [7:0] nxt_intctl;
    always_comb begin
        nxt_intctl = intctl_ff;
        if (wr_intctl) begin
            nxt_intctl = pwdata[7:0] & tmz_pkg::INTCTL_MASK;
        end
        if (wrap) begin
            nxt_intctl[tmz_pkg::IC_OVF_BIT] = 1'b1;
        end
    end

    wire irq_req = intctl_ff[tmz_pkg::IC_OVF_BIT] && intctl_ff[tmz_pkg::IC_OVIE_BIT]
                   && intctl_ff[tmz_pkg::IC_GIE_BIT];

    // Read mux; divider deliberately has no address
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0;
        if (hit_count) begin
            nxt_rdata[7:0] = count_ff;
        end else if (hit_intctl) begin
            nxt_rdata[7:0] = intctl_ff;
        end else if (hit_config) begin
            nxt_rdata[7:0] = config_ff;
        end else if (hit_porta) begin
            nxt_rdata[7:0] = porta_dir_ff;
        end else if (hit_ctrl) begin
            nxt_rdata[tmz_pkg::CTRL_SLEEP_BIT] = sleep_ff;
        end
    end

    wire [1:0] nxt_hold = wr_count ? tmz_pkg::HOLDOFF_CYC :
                          (inst_cycle && hold_ff != 2'h0) ? hold_ff - 2'h1 : hold_ff;
    wire [7:0] nxt_count = wr_count ? pwdata[7:0] : (inc ? count_ff + 8'h01 : count_ff);
    wire [7:0] nxt_div = div_clear ? 8'h00 : (div_step ? div_ff + 8'h01 : div_ff);
    // Watchdog postscaler tick when divider belongs to it
    wire wd_tap = div_ff[ratio];
    wire nxt_wdt_tick = to_wdt && wd_tap && !wd_prev_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= PH1;
            config_ff <= tmz_pkg::CONFIG_RST;
            intctl_ff <= tmz_pkg::INTCTL_RST;
            porta_dir_ff <= tmz_pkg::PORTA_DIR_RST;
            sleep_ff <= 1'b0;
            div_ff <= 8'h00;
            hold_ff <= 2'h0;
        end else begin
            phase_ff <= nxt_phase;
            config_ff <= wr_config ? pwdata[7:0] : config_ff;
            intctl_ff <= nxt_intctl;
            porta_dir_ff <= wr_porta ? pwdata[7:0] : porta_dir_ff;
            sleep_ff <= wr_ctrl ? pwdata[tmz_pkg::CTRL_SLEEP_BIT] : sleep_ff;
            div_ff <= nxt_div;
            hold_ff <= nxt_hold;
        end
    end

    // Count keeps its value across resets
    always_ff @(posedge pclk) begin
        count_ff <= nxt_count;
    end

    // Pin sampling and phase synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Idle level under reset config, so no false edge after reset
            pin_q_ff <= 1'b0;
            src_prev_ff <= 1'b1;
            samp2_ff <= 1'b1;
            samp4_ff <= 1'b1;
            wd_prev_ff <= 1'b0;
        end else begin
            pin_q_ff <= timer_ext_clock_pin;
            src_prev_ff <= src_level;
            samp2_ff <= phase_ff == PH2 ? samp4_ff : samp2_ff;
            samp4_ff <= phase_ff == PH4 ? pre_out : samp4_ff;
            wd_prev_ff <= wd_tap;
        end
    end

    // Outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            wdt_tick_ff <= 1'b0;
            wdt_clear_ff <= 1'b0;
            irq_ff <= 1'b0;
            porta_ff <= 1'b1;
        end else begin
            prdata_ff <= access ? nxt_rdata : 32'h0;
            pready_ff <= access;
            pslverr_ff <= access && !hit_any;
            wdt_tick_ff <= nxt_wdt_tick;
            wdt_clear_ff <= wd_clear_cmd;
            irq_ff <= irq_req;
            porta_ff <= porta_dir_ff[0];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign wdt_tick = wdt_tick_ff;
    assign wdt_clear = wdt_clear_ff;
    assign timer_irq = irq_ff;
    assign port_a_dir_0 = porta_ff;
endmodule : tmz_timer0

// ===== verification/tmz_ext_src.sv
`timescale 1ns/100ps
module tmz_ext_src (
    // Clock
    input wire logic pclk,
    // Count pin
    output logic timer_ext_clock_pin
);
    initial timer_ext_clock_pin = 1'b0;
    // Four cycles a level keeps clear of the sampling phases
    task automatic toggle(input int n);
        repeat (n) begin
            repeat (4) @(posedge pclk);
            timer_ext_clock_pin <= ~timer_ext_clock_pin;
        end
    endtask : toggle
endmodule : tmz_ext_src

// ===== verification/tmz_timer0_assertions.sv
`timescale 1ns/100ps
module tmz_timer0_assertions (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Side outputs
    input wire logic wdt_tick,
    input wire logic wdt_clear,
    input wire logic timer_irq,
    input wire logic port_a_dir_0
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire take = psel && penable && !pready;
    wire wr = take && pwrite;
    wire mapped = paddr == tmz_pkg::ADDR_COUNT || paddr == tmz_pkg::ADDR_INTCTL
        || paddr == tmz_pkg::ADDR_CONFIG || paddr == tmz_pkg::ADDR_PORTA_DIR
        || paddr == tmz_pkg::ADDR_CTRL;
    wire wdir = wr && paddr == tmz_pkg::ADDR_PORTA_DIR;
    property p_answer; take |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err; pready |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("bad error flag");
    property p_rdz; !pready |-> prdata == 32'h0000_0000; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not zero");
    property p_wdclr; wr && paddr == tmz_pkg::ADDR_CTRL && pwdata[1] |-> ##[1:3] wdt_clear;
    endproperty
    a_wdclr: assert property (p_wdclr) else $error("no watchdog clear");
    property p_wdone; wdt_clear |=> !wdt_clear; endproperty
    a_wdone: assert property (p_wdone) else $error("clear too long");
    property p_tick; wdt_tick |=> !wdt_tick; endproperty
    a_tick: assert property (p_tick) else $error("tick too long");
    property p_dir; $changed(port_a_dir_0) |-> $past(wdir, 2) || $past(wdir, 3); endproperty
    a_dir: assert property (p_dir) else $error("direction moved alone");
    property p_gie; wr && paddr == tmz_pkg::ADDR_INTCTL && !pwdata[7] |-> ##[1:3] !timer_irq;
    endproperty
    a_gie: assert property (p_gie) else $error("request not masked");
    c_wr: cover property (wr);
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(timer_irq));
endmodule : tmz_timer0_assertions
bind tmz_timer0 tmz_timer0_assertions chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .wdt_tick, .wdt_clear, .timer_irq,
    .port_a_dir_0);

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam logic [11:0] A_CNT = tmz_pkg::ADDR_COUNT;
    localparam logic [11:0] A_IC = tmz_pkg::ADDR_INTCTL;
    localparam logic [11:0] A_CFG = tmz_pkg::ADDR_CONFIG;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, rd2;
    logic pready, pslverr, err, ext_pin, wdt_tick, wdt_clear, timer_irq, port_a_dir_0;
    int mismatches = 0;
    int n_tests = 0;
    tmz_timer0 tmz_timer0_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .timer_ext_clock_pin(ext_pin), .wdt_tick, .wdt_clear,
        .timer_irq, .port_a_dir_0);
    tmz_ext_src tmz_ext_src_i (.pclk, .timer_ext_clock_pin(ext_pin));
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            mismatches++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Two count reads exactly p cycles apart
    task automatic gap(input int p, input logic [7:0] exp);
        logic [7:0] dd;
        xfer(1'b0, A_CNT, 32'h0);
        rd2 = rd;
        repeat (p - 4) @(posedge pclk);
        xfer(1'b0, A_CNT, 32'h0);
        dd = rd[7:0] - rd2[7:0];
        check({24'h0, dd}, {24'h0, exp});
    endtask : gap
    task automatic t_reset;
        xfer(1'b0, A_CFG, 32'h0);
        check(rd, 32'h0000_00FF);
        xfer(1'b0, A_IC, 32'h0);
        check(rd, 32'h0000_0000);
        xfer(1'b0, 12'h008, 32'h0);
        check({31'h0, err}, 32'h0000_0001);
    endtask : t_reset
    task automatic t_count;
        xfer(1'b1, A_CFG, 32'h08);
        xfer(1'b1, A_CNT, 32'h10);
        xfer(1'b0, A_CNT, 32'h0);
        check(rd, 32'h0000_0010);
        repeat (12) @(posedge pclk);
        gap(40, 8'h0A);
        xfer(1'b1, tmz_pkg::ADDR_CTRL, 32'h2);
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, A_CFG, c);
            xfer(1'b1, A_CNT, 32'h0);
            gap(16 * (2 << c), 8'h04);
        end
    endtask : t_count
    task automatic t_ext(input logic [7:0] cfg, input int n, input logic [31:0] exp);
        xfer(1'b1, A_CFG, {24'h0, cfg});
        xfer(1'b1, A_CNT, 32'h0);
        repeat (12) @(posedge pclk);
        tmz_ext_src_i.toggle(n);
        repeat (12) @(posedge pclk);
        xfer(1'b0, A_CNT, 32'h0);
        check(rd, exp);
    endtask : t_ext
    task automatic t_irq(input logic [31:0] ic, input logic exp);
        xfer(1'b1, A_IC, ic);
        repeat (3) @(posedge pclk);
        check({31'h0, timer_irq}, {31'h0, exp});
        xfer(1'b0, A_IC, 32'h0);
        check(rd, ic);
    endtask : t_irq
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_count();
        t_ext(8'h28, 5, 32'h3);
        t_ext(8'h38, 5, 32'h3);
        t_ext(8'h20, 8, 32'h2);
        xfer(1'b1, A_CFG, 32'h08);
        xfer(1'b1, A_CNT, 32'hFE);
        repeat (30) @(posedge pclk);
        t_irq(32'h04, 1'b0);
        t_irq(32'hA4, 1'b1);
        t_irq(32'h24, 1'b0);
        t_irq(32'hA0, 1'b0);
        xfer(1'b1, tmz_pkg::ADDR_CTRL, 32'h1);
        gap(40, 8'h00);
        xfer(1'b1, tmz_pkg::ADDR_PORTA_DIR, 32'h0);
        repeat (3) @(posedge pclk);
        check({31'h0, port_a_dir_0}, 32'h0);
        complete_run();
    end
endmodule : testbench
